// ===== rtl/sadc_device.sv
// Contract
// RULE_01: start rising edge holds all, begins sequence
// RULE_02: source low uses pins, high uses register
// RULE_03: write cycle stores low four data lines
// RULE_04: selection captured only at start edge
// RULE_05: busy rises at start, stays until done
// RULE_06: clock source high selects external clock
// RULE_07: end-of-conversion marks each channel done
// RULE_08: sequence end drops busy, releases holds
// RULE_09: host reads after busy or each pulse
// RULE_10: twelve-bit results read with select, read
// RULE_11: each channel converts in 1.65 us
// RULE_12: host waits 0.35 us acquisition
// RULE_13: host avoids reads near conversions
// RULE_14: ascending channel order, unselected skipped
// RULE_15: bit 0 is channel 1, bit 3 channel 4
// RULE_16: end-of-conversion is a low pulse
// RULE_17: no start while busy or acquiring
`include "sadc_regs.svh"
`default_nettype none
// ==========================================================
// converter end: sequencer, result buffer, parallel port
module sadc_device import sadc_pkg::*; #(
	parameter int CONV_CYC = `SADC_CONV_CYC,
	parameter int EXT_TICKS = `SADC_EXT_TICKS,
	parameter int DATA_W = `SADC_DATA_W,
	parameter int FIFO_DEPTH = 2
) (
	input wire logic CLK_IN,
	input wire logic RST_N_IN,
	sadc_if.dev BUS,
	input wire logic [DATA_W-1:0] RESULT_IN,
	output logic [1:0] CUR_CH_OUT,
	output logic [3:0] HOLD_OUT,
	output logic SEQ_STALL_OUT
);
	localparam int AW = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
	// ==========================================================
	// channel decode helpers
	function automatic logic [1:0] first_ch(input logic [3:0] m);
		first_ch = 2'h0;
		for (int i = 3; i >= 0; i--) begin
			if (m[i]) begin
				first_ch = 2'(i); //RULE_14
			end
		end
	endfunction
	function automatic logic [3:0] ch_bit(input logic [1:0] c);
		ch_bit = 4'h1 << c; //RULE_15
	endfunction
	// ==========================================================
	// pin inputs: two flops, then a history flop for edges
	logic [14:0] s1_reg, s2_reg, s3_reg, pins;
	logic st_n_s, cs_n_s, rd_n_s, wr_n_s, src_s, csel_s, eclk_s;
	logic [3:0] hw_s, dbl_s;
	logic st_n_p, rd_act_p, wr_act_p, eclk_p;
	assign pins = {BUS.conversion_start_n, BUS.cs_n, BUS.rd_n, BUS.wr_n,
		BUS.selection_source, BUS.clock_source_select,
		BUS.external_clock_input, BUS.hw_channel_select_pins, BUS.db[3:0]};
	assign {st_n_s, cs_n_s, rd_n_s, wr_n_s, src_s, csel_s, eclk_s, hw_s,
		dbl_s} = s2_reg;
	assign st_n_p = s3_reg[14];
	assign eclk_p = s3_reg[8];
	assign rd_act_p = ~s3_reg[13] & ~s3_reg[12];
	assign wr_act_p = ~s3_reg[13] & ~s3_reg[11];
	// idle pin levels: strobes high, everything else low
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			s1_reg <= 15'h7800;
			s2_reg <= 15'h7800;
			s3_reg <= 15'h7800;
		end else begin
			s1_reg <= pins;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end
	logic start_rise, rd_act, rd_end, wr_end, tick;
	assign start_rise = st_n_s & ~st_n_p; //RULE_01
	assign rd_act = ~cs_n_s & ~rd_n_s;
	assign rd_end = rd_act_p & ~rd_act;
	assign wr_end = wr_act_p & (cs_n_s | wr_n_s);
	// external clock counts rising edges; internal counts every cycle
	assign tick = csel_s ? (eclk_s & ~eclk_p) : 1'b1; //RULE_06
	// ==========================================================
	// channel select register
	logic [3:0] chsel_reg, chsel_next;
	always_comb begin
		chsel_next = chsel_reg;
		if (wr_end) begin
			chsel_next = dbl_s; //RULE_03 RULE_15
		end
	end
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			chsel_reg <= `SADC_CHSEL_RESET;
		end else begin
			chsel_reg <= chsel_next;
		end
	end
	// ==========================================================
	// two-entry result buffer; a full buffer stalls the sequencer
	logic [DATA_W-1:0] mem_reg [FIFO_DEPTH];
	logic [AW-1:0] wp_reg, wp_next, rp_reg, rp_next;
	logic [AW:0] cnt_reg, cnt_next;
	logic in_valid, in_ready, out_valid, out_ready;
	assign in_ready = (cnt_reg != (AW+1)'(FIFO_DEPTH));
	assign out_valid = (cnt_reg != '0);
	assign out_ready = rd_end; // a finished read cycle pops
	always_comb begin
		wp_next = wp_reg;
		rp_next = rp_reg;
		cnt_next = cnt_reg;
		if (in_valid & in_ready) begin
			wp_next = (wp_reg == AW'(FIFO_DEPTH - 1)) ? '0 : wp_reg + 1'b1;
		end
		if (out_valid & out_ready) begin
			rp_next = (rp_reg == AW'(FIFO_DEPTH - 1)) ? '0 : rp_reg + 1'b1;
		end
		case ({in_valid & in_ready, out_valid & out_ready})
			2'b10: cnt_next = cnt_reg + 1'b1;
			2'b01: cnt_next = cnt_reg - 1'b1;
			default: cnt_next = cnt_reg;
		endcase
	end
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			wp_reg <= '0;
			rp_reg <= '0;
			cnt_reg <= '0;
		end else begin
			wp_reg <= wp_next;
			rp_reg <= rp_next;
			cnt_reg <= cnt_next;
		end
	end
	// storage has no reset; only written entries are ever read
	always_ff @(posedge CLK_IN) begin
		if (in_valid & in_ready) begin
			mem_reg[wp_reg] <= RESULT_IN;
		end
	end
	// ==========================================================
	// parallel read port, data and enable from flops
	logic [DATA_W-1:0] dout_reg, dout_next;
	logic doe_reg, doe_next;
	always_comb begin
		doe_next = rd_act; //RULE_10
		dout_next = dout_reg;
		if (rd_act & out_valid) begin
			dout_next = mem_reg[rp_reg];
		end
	end
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			dout_reg <= '0;
			doe_reg <= 1'b0;
		end else begin
			dout_reg <= dout_next;
			doe_reg <= doe_next;
		end
	end
	// ==========================================================
	// conversion sequencer
	sadc_dev_state_t st_reg, st_next;
	logic [15:0] cc_reg, cc_next;
	logic [3:0] pend_reg, pend_next, hold_reg, hold_next, sel, left;
	logic [1:0] ch_reg, ch_next;
	logic busy_reg, busy_next, eoc_reg, eoc_next;
	logic [15:0] last_tick;
	assign last_tick = csel_s ? 16'(EXT_TICKS - 1) : 16'(CONV_CYC - 1);
	assign sel = src_s ? chsel_reg : hw_s; //RULE_02
	assign left = pend_reg & ~ch_bit(ch_reg);
	always_comb begin
		st_next = st_reg;
		cc_next = cc_reg;
		pend_next = pend_reg;
		hold_next = hold_reg;
		ch_next = ch_reg;
		busy_next = busy_reg;
		eoc_next = 1'b1;
		in_valid = 1'b0;
		case (st_reg)
			DS_IDLE: begin
				// an empty selection starts nothing
				if (start_rise && sel != 4'h0) begin
					pend_next = sel; //RULE_04
					ch_next = first_ch(sel); //RULE_14
					hold_next = 4'hF; //RULE_01
					busy_next = 1'b1; //RULE_05
					cc_next = 16'h0000;
					st_next = DS_CONV;
				end
			end
			DS_CONV: begin
				if (tick) begin
					cc_next = cc_reg + 16'h0001;
					if (cc_reg >= last_tick) begin
						st_next = DS_PUSH; //RULE_11
					end
				end
			end
			DS_PUSH: begin
				in_valid = 1'b1;
				if (in_ready) begin
					eoc_next = 1'b0; //RULE_07 RULE_16
					pend_next = left;
					cc_next = 16'h0000;
					if (left == 4'h0) begin
						busy_next = 1'b0; //RULE_08
						hold_next = 4'h0; //RULE_08
						st_next = DS_IDLE;
					end else begin
						ch_next = first_ch(left); //RULE_14
						st_next = DS_CONV;
					end
				end
			end
			default: begin
				st_next = DS_IDLE;
				busy_next = 1'b0;
				hold_next = 4'h0;
			end
		endcase
	end
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			st_reg <= DS_IDLE;
			cc_reg <= 16'h0000;
			pend_reg <= 4'h0;
			hold_reg <= 4'h0;
			ch_reg <= 2'h0;
			busy_reg <= 1'b0;
			eoc_reg <= 1'b1;
		end else begin
			st_reg <= st_next;
			cc_reg <= cc_next;
			pend_reg <= pend_next;
			hold_reg <= hold_next;
			ch_reg <= ch_next;
			busy_reg <= busy_next;
			eoc_reg <= eoc_next;
		end
	end
	// ==========================================================
	// outputs
	assign BUS.busy = busy_reg;
	assign BUS.eoc_n = eoc_reg;
	assign BUS.db_dev_out = dout_reg;
	assign BUS.db_dev_oe = doe_reg;
	assign CUR_CH_OUT = ch_reg;
	assign HOLD_OUT = hold_reg;
	assign SEQ_STALL_OUT = (st_reg == DS_PUSH) & ~in_ready;
endmodule
`default_nettype wire

// ===== pkg/sadc_regs.svh
`ifndef SADC_REGS_SVH
`define SADC_REGS_SVH
// ==========================================================
// widths
`define SADC_DATA_W 12
`define SADC_NCH 4
`define SADC_CHSEL_RESET 4'h0
// ==========================================================
// timing, in ns and in 20 ns cycles
`define SADC_CLK_NS 20
`define SADC_CONV_NS 1650
// longest time: rounds down
`define SADC_CONV_CYC (`SADC_CONV_NS / `SADC_CLK_NS)
`define SADC_ACQ_NS 350
// least time: rounds up
`define SADC_ACQ_CYC ((`SADC_ACQ_NS + `SADC_CLK_NS - 1) / `SADC_CLK_NS)
`define SADC_EXT_TICKS 14
`define SADC_EXT_DIV 2
`define SADC_START_LOW 3
`define SADC_GUARD 8
`define SADC_STROBE_LOW 8
`define SADC_BUS_GAP 6
`endif

// ===== pkg/sadc_pkg.sv
`default_nettype none
// ==========================================================
// shared types
package sadc_pkg;
	typedef enum logic [2:0] {
		DS_IDLE = 3'h1,
		DS_CONV = 3'h2,
		DS_PUSH = 3'h4
	} sadc_dev_state_t;
	typedef enum logic [4:0] {
		HS_IDLE = 5'h01,
		HS_START = 5'h02,
		HS_GUARD = 5'h04,
		HS_READ = 5'h08,
		HS_WRITE = 5'h10
	} sadc_host_state_t;
endpackage
`default_nettype wire

// ===== pkg/sadc_if.sv
`default_nettype none
// ==========================================================
// pins between converter and host
interface sadc_if;
	logic conversion_start_n;
	logic busy;
	logic eoc_n;
	logic cs_n;
	logic rd_n;
	logic wr_n;
	logic [3:0] hw_channel_select_pins;
	logic selection_source;
	logic clock_source_select;
	logic external_clock_input;
	logic [11:0] db_dev_out;
	logic db_dev_oe;
	logic [11:0] db_host_out;
	logic db_host_oe;
	logic [11:0] db;
	// shared data wire; reads as zero when nobody drives
	assign db = db_dev_oe ? db_dev_out :
		(db_host_oe ? db_host_out : 12'h000);
	modport dev (
		input conversion_start_n, cs_n, rd_n, wr_n,
		input hw_channel_select_pins, selection_source,
		input clock_source_select, external_clock_input, db,
		output busy, eoc_n, db_dev_out, db_dev_oe
	);
	modport host (
		output conversion_start_n, cs_n, rd_n, wr_n,
		output hw_channel_select_pins, selection_source,
		output clock_source_select, external_clock_input,
		output db_host_out, db_host_oe,
		input busy, eoc_n, db
	);
endinterface
`default_nettype wire

// ===== rtl/sadc_host.sv
`include "sadc_regs.svh"
`default_nettype none
// ==========================================================
// host end: start pulses, channel register writes, result reads
module sadc_host import sadc_pkg::*; #(
	parameter int EXT_DIV = `SADC_EXT_DIV
) (
	input wire logic CLK_IN,
	input wire logic RST_N_IN,
	sadc_if.host BUS,
	input wire logic START_IN,
	output logic START_READY_OUT,
	input wire logic [3:0] HW_SEL_IN,
	input wire logic SEL_SOURCE_IN,
	input wire logic EXT_CLK_EN_IN,
	input wire logic SW_SEL_WR_IN,
	input wire logic [3:0] SW_SEL_IN,
	output logic WR_READY_OUT,
	input wire logic READ_EACH_IN,
	output logic [11:0] RESULT_OUT,
	output logic RESULT_VALID_OUT
);
	localparam int TOTAL = `SADC_STROBE_LOW + `SADC_BUS_GAP;
	// ==========================================================
	// pin inputs: two flops, then edge history
	logic [13:0] s1_reg, s2_reg;
	logic busy_prev_reg, eoc_prev_reg;
	logic busy_s, eoc_s;
	logic [11:0] db_s;
	assign {busy_s, eoc_s, db_s} = s2_reg;
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			s1_reg <= 14'h1000;
			s2_reg <= 14'h1000;
			busy_prev_reg <= 1'b0;
			eoc_prev_reg <= 1'b1;
		end else begin
			s1_reg <= {BUS.busy, BUS.eoc_n, BUS.db};
			s2_reg <= s1_reg;
			busy_prev_reg <= busy_s;
			eoc_prev_reg <= eoc_s;
		end
	end
	// ==========================================================
	// sequencer of bus cycles
	sadc_host_state_t st_reg, st_next;
	logic [7:0] cnt_reg, cnt_next;
	logic [7:0] acq_reg, acq_next;
	logic [2:0] pend_reg, pend_next;
	logic [3:0] wdat_reg, wdat_next;
	logic [11:0] res_reg, res_next;
	logic rv_reg, rv_next;
	logic start_n_reg, start_n_next;
	logic strobe_reg, strobe_next;
	logic eoc_fall, can_read, can_start;
	assign eoc_fall = eoc_prev_reg & ~eoc_s;
	// per-result reads may overlap a conversion; the quiet mode waits
	assign can_read = (pend_reg != 3'h0) & (READ_EACH_IN | ~busy_s); //RULE_09 RULE_13
	// no new start while busy or acquiring
	assign can_start = ~busy_s & (acq_reg == 8'h00); //RULE_12 RULE_17
	assign START_READY_OUT = (st_reg == HS_IDLE) & ~can_read & can_start;
	assign WR_READY_OUT = (st_reg == HS_IDLE) & ~can_read;
	always_comb begin
		st_next = st_reg;
		cnt_next = cnt_reg;
		acq_next = acq_reg;
		pend_next = pend_reg;
		wdat_next = wdat_reg;
		res_next = res_reg;
		rv_next = 1'b0;
		start_n_next = start_n_reg;
		strobe_next = strobe_reg;
		if (busy_prev_reg & ~busy_s) begin
			acq_next = 8'(`SADC_ACQ_CYC); //RULE_12
		end else if (acq_reg != 8'h00) begin
			acq_next = acq_reg - 8'h01;
		end
		if (eoc_fall) begin
			pend_next = pend_next + 3'h1;
		end
		case (st_reg)
			HS_IDLE: begin
				cnt_next = 8'h00;
				if (can_read) begin
					st_next = HS_READ;
					strobe_next = 1'b1;
					pend_next = pend_next - 3'h1;
				end else if (SW_SEL_WR_IN) begin
					st_next = HS_WRITE; //RULE_03
					strobe_next = 1'b1;
					wdat_next = SW_SEL_IN;
				end else if (START_IN & can_start) begin
					st_next = HS_START;
					start_n_next = 1'b0;
				end
			end
			HS_START: begin
				cnt_next = cnt_reg + 8'h01;
				if (cnt_reg == 8'(`SADC_START_LOW - 1)) begin
					start_n_next = 1'b1; // rising edge starts it
					st_next = HS_GUARD;
					cnt_next = 8'h00;
				end
			end
			HS_GUARD: begin
				// covers the round trip until busy is seen high
				cnt_next = cnt_reg + 8'h01;
				if (cnt_reg == 8'(`SADC_GUARD - 1)) begin
					st_next = HS_IDLE;
				end
			end
			HS_READ, HS_WRITE: begin
				cnt_next = cnt_reg + 8'h01;
				if (cnt_reg == 8'(`SADC_STROBE_LOW - 1)) begin
					strobe_next = 1'b0;
					if (st_reg == HS_READ) begin
						res_next = db_s; //RULE_10
						rv_next = 1'b1;
					end
				end
				if (cnt_reg == 8'(TOTAL - 1)) begin
					st_next = HS_IDLE;
				end
			end
			default: begin
				st_next = HS_IDLE;
			end
		endcase
	end
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			st_reg <= HS_IDLE;
			cnt_reg <= 8'h00;
			acq_reg <= 8'h00;
			pend_reg <= 3'h0;
			wdat_reg <= 4'h0;
			res_reg <= 12'h000;
			rv_reg <= 1'b0;
			start_n_reg <= 1'b1;
			strobe_reg <= 1'b0;
		end else begin
			st_reg <= st_next;
			cnt_reg <= cnt_next;
			acq_reg <= acq_next;
			pend_reg <= pend_next;
			wdat_reg <= wdat_next;
			res_reg <= res_next;
			rv_reg <= rv_next;
			start_n_reg <= start_n_next;
			strobe_reg <= strobe_next;
		end
	end
	// ==========================================================
	// static pins and the external conversion clock divider
	logic [3:0] hw_reg;
	logic src_reg, csel_reg, eclk_reg, eclk_next;
	logic [7:0] div_reg, div_next;
	always_comb begin
		div_next = div_reg + 8'h01;
		eclk_next = eclk_reg;
		if (!EXT_CLK_EN_IN) begin
			div_next = 8'h00;
		end else if (div_reg == 8'(EXT_DIV - 1)) begin
			div_next = 8'h00;
			eclk_next = ~eclk_reg; //RULE_06
		end
	end
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			hw_reg <= 4'h0;
			src_reg <= 1'b0;
			csel_reg <= 1'b0;
			eclk_reg <= 1'b0;
			div_reg <= 8'h00;
		end else begin
			hw_reg <= HW_SEL_IN;
			src_reg <= SEL_SOURCE_IN;
			csel_reg <= EXT_CLK_EN_IN;
			eclk_reg <= eclk_next;
			div_reg <= div_next;
		end
	end
	// ==========================================================
	// pin drive
	assign BUS.conversion_start_n = start_n_reg;
	assign BUS.cs_n = ~strobe_reg;
	assign BUS.rd_n = ~(strobe_reg & (st_reg == HS_READ));
	assign BUS.wr_n = ~(strobe_reg & (st_reg == HS_WRITE));
	assign BUS.db_host_oe = (st_reg == HS_WRITE);
	assign BUS.db_host_out = {8'h00, wdat_reg};
	assign BUS.hw_channel_select_pins = hw_reg;
	assign BUS.selection_source = src_reg;
	assign BUS.clock_source_select = csel_reg;
	assign BUS.external_clock_input = eclk_reg;
	assign RESULT_OUT = res_reg;
	assign RESULT_VALID_OUT = rv_reg;
endmodule
`default_nettype wire

// ===== verif/sadc_checker.sv
`include "sadc_regs.svh"
`default_nettype none
// ==========================================================
// pin-level checks on the converter/host interface
module sadc_checker (
	input wire logic CLK_IN,
	input wire logic RST_N_IN,
	input wire logic conversion_start_n,
	input wire logic busy,
	input wire logic eoc_n,
	input wire logic cs_n,
	input wire logic rd_n,
	input wire logic db_dev_oe,
	input wire logic db_host_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge CLK_IN);
	endclocking
	default disable iff (!RST_N_IN);
	// cycles since busy was last high; saturates so reset reads as long ago
	logic [7:0] since_busy_reg;
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			since_busy_reg <= 8'hFF;
		end else if (busy) begin
			since_busy_reg <= 8'h00;
		end else if (since_busy_reg != 8'hFF) begin
			since_busy_reg <= since_busy_reg + 8'h01;
		end
	end
	// ==========================================================
	// named steps
	sequence s_eoc_pulse;
		$fell(eoc_n) ##1 eoc_n;
	endsequence
	sequence s_read_strobe;
		$fell(rd_n) && !cs_n;
	endsequence
	// busy only follows a recent start rise (sync delay tolerated)
	property p_busy_rise;
		$rose(busy) |-> $past(conversion_start_n) &&
			!$past(conversion_start_n, 6);
	endproperty
	a_busy_rise: assert property (p_busy_rise)
		else $error("busy rose without a start edge");
	// end-of-conversion low for exactly one cycle
	property p_eoc_pulse;
		$fell(eoc_n) |-> s_eoc_pulse;
	endproperty
	a_eoc_pulse: assert property (p_eoc_pulse)
		else $error("eoc pulse not one cycle wide");
	// busy falls together with the last eoc pulse
	property p_busy_end;
		$fell(busy) |-> !eoc_n || !$past(eoc_n);
	endproperty
	a_busy_end: assert property (p_busy_end)
		else $error("busy fell without a final eoc");
	// no eoc outside a sequence
	property p_eoc_in_busy;
		!eoc_n |-> busy || $past(busy);
	endproperty
	a_eoc_in_busy: assert property (p_eoc_in_busy)
		else $error("eoc pulse outside sequence");
	// first conversion keeps eoc high for at least three cycles
	property p_conv_min;
		$rose(busy) |-> eoc_n[*3];
	endproperty
	a_conv_min: assert property (p_conv_min)
		else $error("conversion finished too early");
	// and does finish in bounded time
	property p_conv_max;
		$rose(busy) |-> ##[1:120] !eoc_n;
	endproperty
	a_conv_max: assert property (p_conv_max)
		else $error("conversion never finished");
	// device starts driving only under chip select and read
	property p_oe_on_read;
		$rose(db_dev_oe) |-> !cs_n && !rd_n;
	endproperty
	a_oe_on_read: assert property (p_oe_on_read)
		else $error("device drove bus without read");
	// read data appears three to five cycles after the strobe
	property p_read_latency;
		s_read_strobe |-> ##[3:5] db_dev_oe;
	endproperty
	a_read_latency: assert property (p_read_latency)
		else $error("read data late or missing");
	// shared wire never has two drivers
	property p_one_driver;
		!(db_dev_oe && db_host_oe);
	endproperty
	a_one_driver: assert property (p_one_driver)
		else $error("bus contention");
	// holds are back in track long enough before the next start
	property p_acq_gap;
		$rose(conversion_start_n) |->
			since_busy_reg >= 8'(`SADC_ACQ_CYC);
	endproperty
	a_acq_gap: assert property (p_acq_gap)
		else $error("start inside acquisition time");
	// no start edge while a sequence is still running
	property p_start_idle;
		$rose(conversion_start_n) |-> !busy;
	endproperty
	a_start_idle: assert property (p_start_idle)
		else $error("start edge while busy");
	c_seq: cover property ($fell(busy));
endmodule
`default_nettype wire

// ===== verif/simultaneous_adc_sequencer_tb_top.sv
`default_nettype none
module simultaneous_adc_sequencer_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst_n, start, sel_src, ext_en, sw_wr, read_each;
	logic [3:0] hw_sel, sw_sel, hold;
	logic [1:0] cur_ch;
	logic [11:0] result, result_code;
	logic start_rdy, wr_rdy, res_valid, stall, stall_seen, busy_hit;
	int err_total, total_checks, n_results;
	sadc_if bus_if();
	// converter code carries its channel so order is visible
	assign result_code = {8'hC3, 2'h0, cur_ch};
	sadc_device #(.CONV_CYC(4)) i_sadc_device (.CLK_IN(clk),
		.RST_N_IN(rst_n), .BUS(bus_if), .RESULT_IN(result_code),
		.CUR_CH_OUT(cur_ch), .HOLD_OUT(hold), .SEQ_STALL_OUT(stall));
	sadc_host i_sadc_host (.CLK_IN(clk), .RST_N_IN(rst_n),
		.BUS(bus_if), .START_IN(start), .START_READY_OUT(start_rdy),
		.HW_SEL_IN(hw_sel), .SEL_SOURCE_IN(sel_src),
		.EXT_CLK_EN_IN(ext_en), .SW_SEL_WR_IN(sw_wr),
		.SW_SEL_IN(sw_sel), .WR_READY_OUT(wr_rdy),
		.READ_EACH_IN(read_each), .RESULT_OUT(result),
		.RESULT_VALID_OUT(res_valid));
	sadc_checker i_sadc_checker (.CLK_IN(clk), .RST_N_IN(rst_n),
		.conversion_start_n(bus_if.conversion_start_n),
		.busy(bus_if.busy), .eoc_n(bus_if.eoc_n), .cs_n(bus_if.cs_n),
		.rd_n(bus_if.rd_n), .db_dev_oe(bus_if.db_dev_oe),
		.db_host_oe(bus_if.db_host_oe));
	// ==========================================================
	// clock and monitors
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// count every delivered word, note buffer back-pressure
	always @(posedge clk) begin
		if (res_valid === 1'b1) n_results++;
		if (stall === 1'b1) stall_seen = 1'b1;
	end
	// ==========================================================
	// helpers
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [11:0] e,
		input logic [11:0] g);
		total_checks++;
		if (e !== g) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	// bounded wait for a level; a timeout ends the run
	task automatic wait_for(input string nm, ref logic s,
		input logic lvl, input int lim);
		int n;
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while (s !== lvl && n < lim);
		if (s !== lvl) begin
			err_total++;
			$display("ERROR %s expected %b seen %b", nm, lvl, s);
			give_verdict();
		end
	endtask
	task automatic write_sel(input logic [3:0] v);
		wait_for("wr_ready", wr_rdy, 1'b1, 50);
		@(posedge clk) begin
			sw_wr <= 1'b1;
			sw_sel <= v;
		end
		@(posedge clk) sw_wr <= 1'b0;
	endtask
	// one full sequence: start, hold check, ordered words, release
	task automatic run_seq(input logic src, input logic [3:0] hw,
		input logic ext, input logic each, input logic [3:0] sel);
		@(posedge clk) sel_src <= src;
		hw_sel <= hw;
		ext_en <= ext;
		read_each <= each;
		wait_for("start_ready", start_rdy, 1'b1, 100);
		@(posedge clk) start <= 1'b1;
		@(posedge clk) start <= 0;
		wait_for("busy", bus_if.busy, 1'b1, 20);
		chk("hold", 12'h00F, {8'h00, hold});
		// late change must not alter this sequence
		@(posedge clk) hw_sel <= ~hw;
		for (int c = 0; c < 4; c++) begin
			if (sel[c]) begin
				wait_for("valid", res_valid, 1'b1, 600);
				chk("word", {8'hC3, 2'h0, c[1:0]}, result);
			end
		end
		wait_for("busy_low", bus_if.busy, 1'b0, 600);
		chk("track", 12'h000, {8'h00, hold});
		$display("sequence src %b hw %h ext %b done", src, hw, ext);
	endtask
	// ==========================================================
	// main sequence
	initial begin
		rst_n = 1'b0;
		start = 1'b0;
		sel_src = 1'b0;
		ext_en = 1'b0;
		sw_wr = 1'b0;
		read_each = 1'b1;
		hw_sel = 4'h0;
		sw_sel = 4'h0;
		stall_seen = 1'b0;
		err_total = 0;
		total_checks = 0;
		n_results = 0;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		run_seq(1'b0, 4'hB, 1'b0, 1'b1, 4'hB);
		write_sel(4'hC);
		run_seq(1'b1, 4'h3, 1'b0, 1'b0, 4'hC);
		run_seq(1'b0, 4'hF, 1'b1, 1'b1, 4'hF);
		run_seq(1'b0, 4'h1, 1'b0, 1'b1, 4'h1);
		// empty selection is refused: busy must never rise in the window
		@(posedge clk) hw_sel <= 4'h0;
		wait_for("start_ready", start_rdy, 1'b1, 100);
		@(posedge clk) start <= 1'b1;
		@(posedge clk) start <= 1'b0;
		busy_hit = 1'b0;
		repeat (30) begin
			@(posedge clk);
			#1;
			busy_hit = busy_hit | bus_if.busy;
		end
		chk("busy_empty", 12'h000, {11'h000, busy_hit});
		chk("words", 12'h00A, n_results[11:0]);
		chk("stall_seen", 12'h001, {11'h000, stall_seen});
		$display("refusal and totals done");
		give_verdict();
	end
endmodule
`default_nettype wire
